//--- src/pmwd_pkg.sv
// Shared constants and types for the power mode and watchdog control block
package pmwd_pkg;
   // SFR addresses
   localparam logic [7:0] PMWD_ADDR_PWR_CTRL = 8'h87;
   localparam logic [7:0] PMWD_ADDR_WD_RELOAD = 8'ha6;
   localparam logic [7:0] PMWD_ADDR_WD_KEY = 8'ha7;
   // Power control field positions
   localparam int PMWD_BIT_IDLE = 0;
   localparam int PMWD_BIT_PDOWN = 1;
   localparam int PMWD_BIT_GF0 = 2;
   localparam int PMWD_BIT_GF1 = 3;
   localparam int PMWD_BIT_WDLOAD = 4;
   localparam int PMWD_BIT_SPARE5 = 5;
   localparam int PMWD_BIT_AUXDIS = 6;
   localparam int PMWD_BIT_SPARE7 = 7;
   // Reset values
   localparam logic [7:0] PMWD_PWR_CTRL_RST = 8'h00;
   localparam logic [7:0] PMWD_WD_RELOAD_RST = 8'h00;
   localparam logic [7:0] PMWD_WD_KEY_RST = 8'h00;
   // Key value that parks the watchdog
   localparam logic [7:0] PMWD_WD_KEY_OFF = 8'h55;
   // Watchdog prescale in microcontroller clock cycles
   localparam int PMWD_WD_PRESCALE = 12287;
   localparam logic [7:0] PMWD_WD_CNT_TOP = 8'hff;
   // Auxiliary RAM size in bytes, overlapping the bottom of external data space
   localparam int PMWD_AUX_RAM_BYTES = 512;
   localparam logic [15:0] PMWD_AUX_RAM_LIMIT = 16'h0200;

   // SFR access from the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wrData;
      logic wr;
      logic rd;
   } pmwd_sfr_req_t;

   // External data move request from the core
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
   } pmwd_xdata_req_t;

   // Clock enables handed to the clock gating cells
   typedef struct packed {
      logic cpu;
      logic timers;
      logic i2c;
      logic periph;
   } pmwd_clk_en_t;
endpackage

//--- src/pmwd_prescaler.sv
// Free divider that pulses once every DIV cycles while running
`timescale 1ns/1ps
`default_nettype none
module pmwd_prescaler
   import pmwd_pkg::*;
#(
   parameter int DIV = PMWD_WD_PRESCALE,
   parameter int W = $clog2(DIV)
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Control
   input wire logic run,
   input wire logic restart,
   // Tick
   output logic tick
);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   wire atLast = (cnt_q == LAST);

   assign cnt_d = (restart || !run || atLast) ? '0 : cnt_q + W'(1);
   assign tick = run && !restart && atLast;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

//--- src/pmwd_xdata_route.sv
// Steers external data moves between auxiliary RAM and external memory
`timescale 1ns/1ps
`default_nettype none
module pmwd_xdata_route
   import pmwd_pkg::*;
(
   // Control
   input wire logic auxRamDisable,
   // Request from the core
   input wire pmwd_xdata_req_t xReq,
   // Selected targets
   output logic auxSel,
   output logic extSel,
   output logic extRdN,
   output logic extWrN
);
   wire access = xReq.rd || xReq.wr;
   wire inAuxWindow = (xReq.addr < PMWD_AUX_RAM_LIMIT);

   // Low window goes to the aux RAM unless disabled
   assign auxSel = access && inAuxWindow && !auxRamDisable;
   // Above the window external memory is always reached
   assign extSel = access && !auxSel;
   // External strobes stay high during aux RAM accesses
   assign extRdN = !(extSel && xReq.rd);
   assign extWrN = !(extSel && xReq.wr);
endmodule
`default_nettype wire

//--- src/pmwd_top.sv
// Power mode selection, aux RAM steering and watchdog timer
`timescale 1ns/1ps
`default_nettype none
module pmwd_top
   import pmwd_pkg::*;
#(
   parameter int WD_PRESCALE = PMWD_WD_PRESCALE
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // SFR access
   input wire pmwd_sfr_req_t sfrReq,
   output logic sfrHit,
   output logic [7:0] sfrRdData,
   // Wake sources
   input wire logic intPending,
   // External data moves
   input wire pmwd_xdata_req_t xReq,
   output logic auxSel,
   output logic extSel,
   output logic extRdN,
   output logic extWrN,
   // Address latch enable
   input wire logic aleCore,
   output logic alePin,
   // Clock enables
   output pmwd_clk_en_t clkEn,
   // Mode status
   output logic idleActive,
   output logic pdownActive,
   output logic wakeEvent,
   // Watchdog
   output logic wdEnabled,
   output logic wdResetReq
);
   // Power control register bits
   logic idle_q;
   logic idle_d;
   logic pdown_q;
   logic pdown_d;
   logic gf0_q;
   logic gf0_d;
   logic gf1_q;
   logic gf1_d;
   logic spare5_q;
   logic spare5_d;
   logic spare7_q;
   logic spare7_d;
   logic auxDis_q;
   logic auxDis_d;
   logic wdLoadEn_q;
   logic wdLoadEn_d;
   logic wdEnLatch_q;
   logic wdEnLatch_d;
   // Watchdog registers, wake pulse and address latch enable register
   logic [7:0] wdReload_q;
   logic [7:0] wdReload_d;
   logic [7:0] wdKey_q;
   logic [7:0] wdKey_d;
   logic [7:0] wdCnt_q;
   logic [7:0] wdCnt_d;
   logic wakeEvent_q;
   logic wakeEvent_d;
   logic wdReset_q;
   logic wdReset_d;
   logic alePin_q;
   logic alePin_d;

   // Address decode
   wire selPwr = (sfrReq.addr == PMWD_ADDR_PWR_CTRL);
   wire selReload = (sfrReq.addr == PMWD_ADDR_WD_RELOAD);
   wire selKey = (sfrReq.addr == PMWD_ADDR_WD_KEY);
   wire wrPwr = sfrReq.wr && selPwr;
   wire wrReload = sfrReq.wr && selReload;
   wire wrKey = sfrReq.wr && selKey;
   wire [7:0] wd = sfrReq.wrData;

   assign sfrHit = (sfrReq.rd || sfrReq.wr) && (selPwr || selReload || selKey);

   // Read mux; bit 4 reads back the load enable
   wire [7:0] pwrRead = {spare7_q, auxDis_q, spare5_q, wdLoadEn_q,
                         gf1_q, gf0_q, pdown_q, idle_q};
   assign sfrRdData = !sfrReq.rd ? 8'h00 :
                      selPwr ? pwrRead :
                      selReload ? wdReload_q :
                      selKey ? wdKey_q : 8'h00;

   // Wake: an interrupt that the core reports as enabled and active
   wire wakeIdle = idle_q && intPending;
   wire wakePdown = pdown_q && intPending;
   wire wakeAny = wakeIdle || wakePdown;

   // Mode bits: a wake in the same cycle as a write wins, so the
   // core never gets stuck in a mode it has already been woken from
   assign idle_d = wakeIdle ? 1'b0 :
                   wrPwr ? wd[PMWD_BIT_IDLE] : idle_q;
   assign pdown_d = wakePdown ? 1'b0 :
                    wrPwr ? wd[PMWD_BIT_PDOWN] : pdown_q;

   // Plain storage bits
   assign gf0_d = wrPwr ? wd[PMWD_BIT_GF0] : gf0_q;
   assign gf1_d = wrPwr ? wd[PMWD_BIT_GF1] : gf1_q;
   assign spare5_d = wrPwr ? wd[PMWD_BIT_SPARE5] : spare5_q;
   assign spare7_d = wrPwr ? wd[PMWD_BIT_SPARE7] : spare7_q;
   assign auxDis_d = wrPwr ? wd[PMWD_BIT_AUXDIS] : auxDis_q;

   // Enable latch only sets; reset alone clears it
   assign wdEnLatch_d = wdEnLatch_q || (wrPwr && wd[PMWD_BIT_WDLOAD]);

   // Load enable is consumed by a reload write
   wire reloadTaken = wrReload && wdLoadEn_q;
   assign wdLoadEn_d = reloadTaken ? 1'b0 :
                       wrPwr ? wd[PMWD_BIT_WDLOAD] : wdLoadEn_q;

   // Reload register only accepts writes while load is enabled
   assign wdReload_d = reloadTaken ? wd : wdReload_q;

   // Key register keeps any value
   assign wdKey_d = wrKey ? wd : wdKey_q;

   // Watchdog runs when latched on and the key is not the park value
   wire wdRun = wdEnLatch_q && (wdKey_q != PMWD_WD_KEY_OFF);
   // The watchdog clock stops with the rest in power-down
   wire wdClocked = wdRun && !pdown_q;

   logic preTick;

   // Prescaler restarts on each reload so a full interval follows it
   pmwd_prescaler #(
      .DIV(WD_PRESCALE)
   ) u_prescaler (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .run(wdClocked),
      .restart(reloadTaken),
      .tick(preTick)
   );

   wire wdOverflow = preTick && (wdCnt_q == PMWD_WD_CNT_TOP);

   // Counter idles at the reload value, climbs from it, and needs
   // 256 minus reload steps to pass 255
   assign wdCnt_d = (reloadTaken || !wdRun || wdOverflow) ? wdReload_d :
                    preTick ? wdCnt_q + 8'h01 : wdCnt_q;

   // Missed reload gives a one-cycle reset request
   assign wdReset_d = wdOverflow;

   // One-cycle pulse when a mode is left by an interrupt
   assign wakeEvent_d = wakeAny;

   // Address latch enable is held low in power-down
   assign alePin_d = aleCore && !pdown_d;

   // One short process per register keeps each reset value beside its state
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         idle_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_IDLE];
      end else begin
         idle_q <= idle_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         pdown_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_PDOWN];
      end else begin
         pdown_q <= pdown_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         gf0_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_GF0];
      end else begin
         gf0_q <= gf0_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         gf1_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_GF1];
      end else begin
         gf1_q <= gf1_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         spare5_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_SPARE5];
      end else begin
         spare5_q <= spare5_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         spare7_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_SPARE7];
      end else begin
         spare7_q <= spare7_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         auxDis_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_AUXDIS];
      end else begin
         auxDis_q <= auxDis_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdLoadEn_q <= PMWD_PWR_CTRL_RST[PMWD_BIT_WDLOAD];
      end else begin
         wdLoadEn_q <= wdLoadEn_d;
      end
   end

   // Only reset clears the latch
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdEnLatch_q <= 1'b0;
      end else begin
         wdEnLatch_q <= wdEnLatch_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdReload_q <= PMWD_WD_RELOAD_RST;
      end else begin
         wdReload_q <= wdReload_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdKey_q <= PMWD_WD_KEY_RST;
      end else begin
         wdKey_q <= wdKey_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdCnt_q <= PMWD_WD_RELOAD_RST;
      end else begin
         wdCnt_q <= wdCnt_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wdReset_q <= 1'b0;
      end else begin
         wdReset_q <= wdReset_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wakeEvent_q <= 1'b0;
      end else begin
         wakeEvent_q <= wakeEvent_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         alePin_q <= 1'b0;
      end else begin
         alePin_q <= alePin_d;
      end
   end

   // Clock gating: state is kept simply by not clocking it, nothing
   // here is cleared on entry
   assign clkEn.cpu = !idle_q && !pdown_q;
   assign clkEn.timers = !pdown_q;
   assign clkEn.i2c = !pdown_q;
   assign clkEn.periph = !pdown_q && !idle_q;

   pmwd_xdata_route u_route (
      .auxRamDisable(auxDis_q),
      .xReq(xReq),
      .auxSel(auxSel),
      .extSel(extSel),
      .extRdN(extRdN),
      .extWrN(extWrN)
   );

   assign idleActive = idle_q;
   assign pdownActive = pdown_q;
   assign wakeEvent = wakeEvent_q;
   assign wdEnabled = wdRun;
   assign wdResetReq = wdReset_q;
   assign alePin = alePin_q;
endmodule
`default_nettype wire

//--- verification/pmwd_top_props.sv
// Concurrent checks on the power mode and watchdog block ports
`timescale 1ns/1ps
`default_nettype none
module pmwd_top_props
   import pmwd_pkg::*;
#(
   parameter int WD_PRESCALE = PMWD_WD_PRESCALE
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // Requests
   input wire pmwd_sfr_req_t sfrReq,
   input wire logic intPending,
   input wire pmwd_xdata_req_t xReq,
   // Observed outputs
   input wire logic auxSel,
   input wire logic extSel,
   input wire logic alePin,
   input wire pmwd_clk_en_t clkEn,
   input wire logic idleActive,
   input wire logic pdownActive,
   input wire logic wakeEvent,
   input wire logic wdEnabled,
   input wire logic wdResetReq
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   // A pending wake beats a same-cycle write, so entry checks leave it out
   wire pwrWr = sfrReq.wr && sfrReq.addr == PMWD_ADDR_PWR_CTRL && !intPending;
   wire xAct = xReq.rd || xReq.wr;

   chk_low_aux: assert property (auxSel |-> xReq.addr < PMWD_AUX_RAM_LIMIT && !extSel)
      else $error("aux RAM selected outside its window");
   chk_high_ext: assert property (xAct && xReq.addr >= PMWD_AUX_RAM_LIMIT |-> extSel && !auxSel)
      else $error("upper external memory not selected");
   chk_pdown_entry: assert property (pwrWr && sfrReq.wrData[1] |=> pdownActive)
      else $error("power-down not entered");
   chk_idle_entry: assert property (pwrWr && sfrReq.wrData[0] |=> idleActive)
      else $error("idle not entered");
   chk_idle_clocks: assert property (idleActive && !pdownActive |-> clkEn == 4'h6)
      else $error("idle clock enables wrong");
   chk_wake_clear: assert property ((idleActive || pdownActive) && intPending |=> !idleActive && !pdownActive && wakeEvent)
      else $error("wake did not clear mode bits");
   chk_pdown_clocks: assert property (pdownActive |-> clkEn == 4'h0)
      else $error("clock left on in power-down");
   chk_ale_frozen: assert property (pdownActive ##1 pdownActive |-> $stable(alePin))
      else $error("address latch enable moved in power-down");
   chk_key_off: assert property (sfrReq.wr && sfrReq.addr == PMWD_ADDR_WD_KEY && sfrReq.wrData == PMWD_WD_KEY_OFF |=> !wdEnabled)
      else $error("watchdog still enabled after key");
   chk_wd_pulse: assert property (wdResetReq |-> $past(wdEnabled) ##1 !wdResetReq)
      else $error("watchdog reset pulse malformed");

   cov_wake: cover property (wakeEvent);
   cov_wd_fire: cover property (wdResetReq);
   cov_pdown_wake: cover property (pdownActive && intPending);
endmodule
`default_nettype wire

//--- verification/pmwd_top_tb.sv
// Self-checking bench for the power mode and watchdog block
`timescale 1ns/1ps
`default_nettype none
module pmwd_top_tb
   import pmwd_pkg::*;
;
   // Short prescale keeps watchdog runs brief
   localparam int P = 4;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   pmwd_sfr_req_t sfrReq = '0;
   pmwd_xdata_req_t xReq = '0;
   logic intPending = 1'b0;
   logic aleCore = 1'b0;
   logic sfrHit, auxSel, extSel, extRdN, extWrN, alePin, idleActive, pdownActive, wakeEvent, wdEnabled, wdResetReq;
   logic [7:0] sfrRdData;
   pmwd_clk_en_t clkEn;
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;
   int wdSeen = 0;
   int n;

   pmwd_top #(.WD_PRESCALE(P)) u_pmwd_top (.sys_clk(sys_clk), .nrst(nrst), .sfrReq(sfrReq), .sfrHit(sfrHit),
      .sfrRdData(sfrRdData), .intPending(intPending), .xReq(xReq), .auxSel(auxSel), .extSel(extSel),
      .extRdN(extRdN), .extWrN(extWrN), .aleCore(aleCore), .alePin(alePin), .clkEn(clkEn),
      .idleActive(idleActive), .pdownActive(pdownActive), .wakeEvent(wakeEvent), .wdEnabled(wdEnabled),
      .wdResetReq(wdResetReq));

   always #5 sys_clk = ~sys_clk;

   always @(posedge sys_clk) begin
      cyc++;
      if (wdResetReq === 1'b1) begin
         wdSeen++;
      end
      if (cyc == 3000) begin
         fails++;
         test_done();
      end
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfrReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      sfrReq.wr <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      sfrReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
      @(negedge sys_clk);
      chk("sfrRdData", sfrRdData, exp);
   endtask

   task automatic xMove(input logic [15:0] a, input logic w);
      @(posedge sys_clk);
      xReq <= '{addr: a, rd: !w, wr: w};
      @(negedge sys_clk);
   endtask

   // Raise a one-cycle interrupt and expect the wake pulse right after it
   task automatic wake();
      @(posedge sys_clk);
      intPending <= 1'b1;
      @(posedge sys_clk);
      intPending <= 1'b0;
      @(negedge sys_clk);
      chk("wakeEvent", {7'h0, wakeEvent}, 8'h01);
      chk("modeBits", {6'h0, pdownActive, idleActive}, 8'h00);
   endtask

   task automatic t_reset_flags();
      rdChk(PMWD_ADDR_WD_RELOAD, 8'h00);
      rdChk(PMWD_ADDR_WD_KEY, 8'h00);
      chk("sfrHit", {7'h0, sfrHit}, 8'h01);
      wr(PMWD_ADDR_PWR_CTRL, 8'hac);
      rdChk(PMWD_ADDR_PWR_CTRL, 8'hac);
      chk("clkEn", {4'h0, clkEn}, 8'h0f);
      rdChk(8'h88, 8'h00);
      chk("sfrHit", {7'h0, sfrHit}, 8'h00);
   endtask

   task automatic t_route();
      wr(PMWD_ADDR_PWR_CTRL, 8'h00);
      xMove(16'h01ff, 1'b0);
      chk("route", {5'h0, auxSel, extSel, extRdN}, 8'h05);
      wr(PMWD_ADDR_PWR_CTRL, 8'h40);
      chk("route", {5'h0, auxSel, extSel, extRdN}, 8'h02);
      xMove(16'h0200, 1'b0);
      wr(PMWD_ADDR_PWR_CTRL, 8'h00);
      chk("route", {5'h0, auxSel, extSel, extRdN}, 8'h02);
      xMove(16'h0300, 1'b1);
      chk("extWrN", {6'h0, extWrN, extRdN}, 8'h01);
      xMove(16'h0100, 1'b1);
      chk("extWrN", {6'h0, extWrN, auxSel}, 8'h03);
      wr(PMWD_ADDR_PWR_CTRL, 8'h40);
      chk("extWrN", {6'h0, extWrN, auxSel}, 8'h00);
      @(posedge sys_clk);
      xReq <= '0;
   endtask

   task automatic t_modes();
      wr(PMWD_ADDR_PWR_CTRL, 8'h0d);
      chk("clkEn", {4'h0, clkEn}, 8'h06);
      wake();
      rdChk(PMWD_ADDR_PWR_CTRL, 8'h0c);
      wr(PMWD_ADDR_PWR_CTRL, 8'h06);
      chk("clkEn", {4'h0, clkEn}, 8'h00);
      @(posedge sys_clk);
      aleCore <= 1'b1;
      @(posedge sys_clk);
      aleCore <= 1'b0;
      @(negedge sys_clk);
      chk("alePin", {7'h0, alePin}, 8'h00);
      wake();
      rdChk(PMWD_ADDR_PWR_CTRL, 8'h04);
   endtask

   task automatic t_watchdog();
      wr(PMWD_ADDR_PWR_CTRL, 8'h10);
      chk("wdEnabled", {7'h0, wdEnabled}, 8'h01);
      wr(PMWD_ADDR_WD_RELOAD, 8'hf0);
      rdChk(PMWD_ADDR_PWR_CTRL, 8'h00);
      wr(PMWD_ADDR_WD_RELOAD, 8'h10);
      rdChk(PMWD_ADDR_WD_RELOAD, 8'hf0);
      chk("wdEnabled", {7'h0, wdEnabled}, 8'h01);
      // Reloads spaced well inside the 8-cycle interval must keep it quiet
      repeat (4) begin
         wr(PMWD_ADDR_PWR_CTRL, 8'h10);
         wr(PMWD_ADDR_WD_RELOAD, 8'hfe);
      end
      chk("wdSeen", wdSeen[7:0], 8'h00);
      n = 0;
      while (wdResetReq !== 1'b1 && n < 100) begin
         @(negedge sys_clk);
         n++;
      end
      chk("interval", n[7:0], 8'((256 - 8'hfe) * P));
      wr(PMWD_ADDR_WD_KEY, PMWD_WD_KEY_OFF);
      chk("wdEnabled", {7'h0, wdEnabled}, 8'h00);
      n = wdSeen;
      repeat (30) @(negedge sys_clk);
      chk("wdSeen", 8'(wdSeen - n), 8'h00);
      wr(PMWD_ADDR_WD_KEY, 8'h01);
      chk("wdEnabled", {7'h0, wdEnabled}, 8'h01);
   endtask

   // A second reset while the watchdog runs must drop the latched enable
   task automatic t_mid_reset();
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(negedge sys_clk);
      chk("wdEnabled", {7'h0, wdEnabled}, 8'h00);
      rdChk(PMWD_ADDR_WD_RELOAD, 8'h00);
      rdChk(PMWD_ADDR_WD_KEY, 8'h00);
   endtask

   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset_flags();
      t_route();
      t_modes();
      t_watchdog();
      t_mid_reset();
      test_done();
   end
endmodule

bind pmwd_top pmwd_top_props #(.WD_PRESCALE(WD_PRESCALE)) u_pmwd_top_props (.sys_clk(sys_clk), .nrst(nrst),
   .sfrReq(sfrReq), .intPending(intPending), .xReq(xReq), .auxSel(auxSel), .extSel(extSel), .alePin(alePin),
   .clkEn(clkEn), .idleActive(idleActive), .pdownActive(pdownActive), .wakeEvent(wakeEvent),
   .wdEnabled(wdEnabled), .wdResetReq(wdResetReq));
`default_nettype wire
